// file: core/awslv_pkg.sv
// Shared constants for the write slave port
package awslv_pkg;
  localparam int          ADDR_W       = 32;
  localparam int          ID_W_MAX     = 16;
  localparam int          BYTE_W       = 8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic        MODE_MEMORY  = 1'h0;
  localparam logic        MODE_PERIPH  = 1'h1;
  localparam int          BUF_DEPTH    = 2;
endpackage

// file: core/awslv_buf_if.sv
// Handshake bundle between the port and its two-entry buffer
`timescale 1ns/1ps
`default_nettype none
interface awslv_buf_if #(
  parameter int WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport src
  (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data
  );
  modport buf_side
  (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data
  );
endinterface
`default_nettype wire

// file: core/awslv_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module awslv_skid #(
  parameter int WIDTH = 8
)(
  input  wire logic    i_clk,
  input  wire logic    i_rstn,
  awslv_buf_if.buf_side bus
);
  logic [WIDTH-1:0] mem_q [awslv_pkg::BUF_DEPTH];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign bus.in_ready  = (count_q != 2'h2);
  assign bus.out_valid = (count_q != 2'h0);
  assign bus.out_data  = mem_q[rd_ptr_q];
  assign push          = bus.in_valid && bus.in_ready;
  assign pop           = bus.out_valid && bus.out_ready;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= bus.in_data;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr_q <= 1'h0;
      rd_ptr_q <= 1'h0;
      count_q  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'h0, push} - {1'h0, pop};
    end
  end
endmodule
`default_nettype wire

// file: core/awslv_write_port.sv
// Write side of a lite slave port in front of a block memory
`timescale 1ns/1ps
`default_nettype none
module awslv_write_port #(
  parameter logic MODE    = awslv_pkg::MODE_MEMORY,
  parameter bit   USE_ID  = 1'b1,
  parameter int   ID_W    = 4,
  parameter int   DATA_W  = 32
)(
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RSTN,
  input  wire logic [31:0]          I_AWADDR,
  input  wire logic                 I_AWVALID,
  output var  logic                 O_AWREADY,
  input  wire logic [ID_W-1:0]      I_AWID,
  input  wire logic [DATA_W-1:0]    I_WDATA,
  input  wire logic [DATA_W/8-1:0]  I_WSTRB,
  input  wire logic                 I_WVALID,
  output var  logic                 O_WREADY,
  output var  logic                 O_BVALID,
  input  wire logic                 I_BREADY,
  output var  logic [ID_W-1:0]      O_BID,
  output var  logic [1:0]           O_BRESP,
  output var  logic [31:0]          O_MEM_ADDR,
  output var  logic [DATA_W-1:0]    O_MEM_DATA,
  output var  logic [DATA_W/8-1:0]  O_MEM_BE
);
  localparam int  STRB_W = DATA_W / awslv_pkg::BYTE_W;
  // ID carried only where the configuration supports it
  localparam bit  ID_ON  = USE_ID && (MODE == awslv_pkg::MODE_MEMORY);
  localparam int  AW_BUF = awslv_pkg::ADDR_W + ID_W;
  localparam int  W_BUF  = DATA_W + STRB_W;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (MODE == awslv_pkg::MODE_MEMORY)
    begin : g_mem_chk
      if (DATA_W != 32 && DATA_W != 64)
        $error("memory style needs 32 or 64 data bits");
    end
    else
    begin : g_per_chk
      if (DATA_W != 8 && DATA_W != 16 && DATA_W != 32 && DATA_W != 64)
        $error("peripheral style needs 8 to 64 data bits");
    end
    if (ID_W < 1 || ID_W > awslv_pkg::ID_W_MAX)
      $error("id width must be 1 to 16");
  endgenerate

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  // Both channels buffered so a held response never drops a word
  awslv_buf_if #(.WIDTH(AW_BUF)) aw_if ();
  awslv_buf_if #(.WIDTH(W_BUF))  w_if ();

  // Ready from a registered copy of buffer space, no combinational path to valid
  logic aw_space_q;
  logic w_space_q;
  logic aw_take;
  logic w_take;
  logic [ID_W-1:0] id_in;

  assign id_in          = ID_ON ? I_AWID : '0;
  assign aw_take        = I_AWVALID && aw_space_q;
  assign w_take         = I_WVALID && w_space_q;
  assign aw_if.in_valid = aw_take;
  assign aw_if.in_data  = {I_AWADDR, id_in};
  assign w_if.in_valid  = w_take;
  assign w_if.in_data   = {I_WDATA, I_WSTRB};

  awslv_skid #(.WIDTH(AW_BUF)) u_aw_buf
  (
    .i_clk  (I_SYS_CLK),
    .i_rstn (I_RSTN),
    .bus    (aw_if.buf_side)
  );

  awslv_skid #(.WIDTH(W_BUF)) u_w_buf
  (
    .i_clk  (I_SYS_CLK),
    .i_rstn (I_RSTN),
    .bus    (w_if.buf_side)
  );

  // Registered ready: one spare slot means a take this cycle still fits
  logic [1:0] aw_cnt_q;
  logic [1:0] w_cnt_q;
  logic       pair_go;

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      aw_cnt_q <= 2'h0;
      w_cnt_q  <= 2'h0;
    end
    else
    begin
      aw_cnt_q <= aw_cnt_q + {1'h0, aw_take} - {1'h0, pair_go};
      w_cnt_q  <= w_cnt_q + {1'h0, w_take} - {1'h0, pair_go};
    end
  end

  // Conservative: ready only when a slot stays free after this cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      aw_space_q <= 1'h0;
      w_space_q  <= 1'h0;
    end
    else
    begin
      aw_space_q <= (aw_cnt_q + {1'h0, aw_take} - {1'h0, pair_go})
                    < 2'(awslv_pkg::BUF_DEPTH);
      w_space_q  <= (w_cnt_q + {1'h0, w_take} - {1'h0, pair_go})
                    < 2'(awslv_pkg::BUF_DEPTH);
    end
  end

  assign O_AWREADY = aw_space_q;
  assign O_WREADY  = w_space_q;

  // ----------------------------------------
  // Pairing and memory write
  // ----------------------------------------
  logic bvalid_q;
  logic resp_free;

  // Response slot frees in the same cycle it is accepted
  assign resp_free       = !bvalid_q || I_BREADY;
  assign pair_go         = aw_if.out_valid && w_if.out_valid && resp_free;
  assign aw_if.out_ready = pair_go;
  assign w_if.out_ready  = pair_go;

  logic [31:0]       mem_addr_q;
  logic [DATA_W-1:0] mem_data_q;
  logic [STRB_W-1:0] mem_be_q;
  logic [STRB_W-1:0] be_d;

  // Byte enables per lane; disabled lanes keep memory contents
  genvar g;
  generate
    for (g = 0; g < STRB_W; g++)
    begin : g_lane
      assign be_d[g] = pair_go && w_if.out_data[g];
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      mem_addr_q <= '0;
      mem_data_q <= '0;
      mem_be_q   <= '0;
    end
    else
    begin
      mem_be_q <= be_d;
      if (pair_go)
      begin
        mem_addr_q <= aw_if.out_data[AW_BUF-1:ID_W];
        mem_data_q <= w_if.out_data[W_BUF-1:STRB_W];
      end
    end
  end

  assign O_MEM_ADDR = mem_addr_q;
  assign O_MEM_DATA = mem_data_q;
  assign O_MEM_BE   = mem_be_q;

  // ----------------------------------------
  // Write response
  // ----------------------------------------
  logic [ID_W-1:0] bid_q;
  logic [1:0]      bresp_q;

  // Status held in a register so every output leaves a flip-flop
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      bresp_q <= awslv_pkg::RESP_OKAY;
    else
      bresp_q <= awslv_pkg::RESP_OKAY;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      bvalid_q <= 1'h0;
    else if (pair_go)
      bvalid_q <= 1'h1;
    else if (I_BREADY)
      bvalid_q <= 1'h0;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      bid_q <= '0;
    else if (pair_go)
      bid_q <= aw_if.out_data[ID_W-1:0];
  end

  assign O_BVALID = bvalid_q;
  // Zero when IDs are absent, as the port has nothing to echo
  assign O_BID    = ID_ON ? bid_q : '0;
  assign O_BRESP  = bresp_q;
endmodule
`default_nettype wire

// file: tb/awslv_properties.sv
// Handshake checker for the write port
`timescale 1ns/1ps
`default_nettype none
module awslv_properties #(
  parameter int ID_W   = 4,
  parameter int DATA_W = 32
)(
  input wire logic                I_SYS_CLK,
  input wire logic                I_RSTN,
  input wire logic                O_AWREADY,
  input wire logic                O_WREADY,
  input wire logic                O_BVALID,
  input wire logic                I_BREADY,
  input wire logic [ID_W-1:0]     O_BID,
  input wire logic [1:0]          O_BRESP,
  input wire logic [DATA_W/8-1:0] O_MEM_BE
);
  // ---
  // Response channel and ready after reset
  // ---
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  sequence s_wait;
    O_BVALID && !I_BREADY;
  endsequence
  sequence s_take;
    O_BVALID && I_BREADY && O_MEM_BE == '0;
  endsequence
  AST_OKAY: assert property (O_BRESP == awslv_pkg::RESP_OKAY)
    else $error("status not okay");
  AST_HOLD: assert property (s_wait |=> O_BVALID && $stable(O_BID))
    else $error("response not held");
  // Slot still full, so no further write may land
  AST_SLOT: assert property (s_wait |=> O_MEM_BE == '0)
    else $error("write while response waits");
  AST_DROP: assert property (s_take |=> !O_BVALID || O_MEM_BE != '0)
    else $error("response stuck");
  AST_ROSE: assert property ($rose(O_BVALID) |-> O_MEM_BE != '0)
    else $error("response without write");
  AST_PAIR: assert property (O_MEM_BE != '0 |-> O_BVALID)
    else $error("write without response");
  AST_AWRDY: assert property ($rose(I_RSTN) |=> O_AWREADY)
    else $error("address ready late");
  AST_WRDY: assert property ($rose(I_RSTN) |=> O_WREADY)
    else $error("data ready late");
endmodule
bind awslv_write_port awslv_properties #(.ID_W(ID_W), .DATA_W(DATA_W))
  u_awslv_properties (.I_SYS_CLK, .I_RSTN, .O_AWREADY, .O_WREADY,
  .O_BVALID, .I_BREADY, .O_BID, .O_BRESP, .O_MEM_BE);
`default_nettype wire

// file: tb/awslv_master.sv
// Bus master model for the write channels
`timescale 1ns/1ps
`default_nettype none
module awslv_master (
  input  wire logic        i_clk,
  input  wire logic        i_awready,
  input  wire logic        i_wready,
  output var  logic [31:0] o_awaddr,
  output var  logic        o_awvalid,
  output var  logic [3:0]  o_awid,
  output var  logic [31:0] o_wdata,
  output var  logic [3:0]  o_wstrb,
  output var  logic        o_wvalid
);
  initial
  begin
    {o_awaddr, o_awvalid, o_awid} = '0;
    {o_wdata, o_wstrb, o_wvalid} = '0;
  end
  // ---
  // One write, both channels at once
  // ---
  // Released lines flip so a stale value never passes
  task automatic send(input logic [31:0] a, input logic [3:0] id,
                      input logic [31:0] d, input logic [3:0] s);
    @(negedge i_clk);
    fork
      begin
        {o_awaddr, o_awid, o_awvalid} = {a, id, 1'b1};
        while (!i_awready) @(negedge i_clk);
        @(negedge i_clk);
        {o_awaddr, o_awid, o_awvalid} = {~a, ~id, 1'b0};
      end
      begin
        {o_wdata, o_wstrb, o_wvalid} = {d, s, 1'b1};
        while (!i_wready) @(negedge i_clk);
        @(negedge i_clk);
        {o_wdata, o_wstrb, o_wvalid} = {~d, ~s, 1'b0};
      end
    join
  endtask
endmodule
`default_nettype wire

// file: tb/axi_lite_write_slave_port_tb.sv
// Self-checking bench for the write port
`timescale 1ns/1ps
`default_nettype none
module axi_lite_write_slave_port_tb;
  logic        clk, rstn, bready, awvalid, awready, wvalid, wready, bvalid;
  logic [31:0] awaddr, wdata, maddr, mdata;
  logic [3:0]  awid, wstrb, bid, mbe;
  logic [1:0]  bresp;
  logic [67:0] mem_q[$];
  logic [3:0]  bid_q[$];
  int          fail_count, check_count, cycles;
  awslv_write_port #(.ID_W(4), .DATA_W(32)) u_awslv_write_port (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWID(awid),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BID(bid), .O_BRESP(bresp), .O_MEM_ADDR(maddr),
    .O_MEM_DATA(mdata), .O_MEM_BE(mbe));
  awslv_master u_awslv_master (.i_clk(clk), .i_awready(awready),
    .i_wready(wready), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .o_awid(awid), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ---
  // Monitor, after the falling-edge drive has landed
  // ---
  always @(negedge clk)
  begin
    #1;
    if (mbe !== 4'h0)
      mem_q.push_back({maddr, mdata, mbe});
    if (bvalid === 1'b1 && bready === 1'b1)
      bid_q.push_back(bid);
  end
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    for (int k = 0; k < 60; k++)
      if (mem_q.size() < n || bid_q.size() < n)
        @(negedge clk);
    check(mem_q.size(), n);
    check(bid_q.size(), n);
  endtask
  task automatic expect_wr(input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [3:0] id);
    logic [67:0] m;
    logic [31:0] k;
    m = mem_q.pop_front();
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    check(m[67:36], a);
    check(m[35:4] & k, d & k);
    check(m[3:0], s);
    check(bid_q.pop_front(), id);
  endtask
  // ---
  // Scenarios
  // ---
  task automatic t_lanes();
    for (int i = 0; i < 5; i++)
    begin
      u_awslv_master.send(32'(4 * i), 4'(i), 32'hcafe_f00d, 4'(9 * i + 1));
      settle(1);
      expect_wr(32'(4 * i), 32'hcafe_f00d, 4'(9 * i + 1), 4'(i));
      check(bresp, awslv_pkg::RESP_OKAY);
    end
  endtask
  // Three writes fill the slot and both buffers
  task automatic t_stall();
    bready = 1'b0;
    for (int i = 0; i < 3; i++)
      u_awslv_master.send(32'h200 + 32'(4 * i), 4'(5 + i),
                          32'h5a5a_0000 + 32'(i), 4'hf);
    repeat (4) @(negedge clk);
    check(awready, 1'b0);
    check(wready, 1'b0);
    check(bvalid, 1'b1);
    check(mem_q.size(), 1);
    bready = 1'b1;
    settle(3);
    for (int i = 0; i < 3; i++)
      expect_wr(32'h200 + 32'(4 * i), 32'h5a5a_0000 + 32'(i), 4'hf,
                4'(5 + i));
  endtask
  // Reset in mid-run drops a waiting response and restarts cleanly
  task automatic t_reset();
    bready = 1'b0;
    u_awslv_master.send(32'h300, 4'h3, 32'h1234_5678, 4'hf);
    repeat (3) @(negedge clk);
    check(bvalid, 1'b1);
    rstn = 1'b0;
    @(negedge clk);
    check(bvalid, 1'b0);
    check(awready, 1'b0);
    check(wready, 1'b0);
    rstn = 1'b1;
    @(negedge clk);
    check(awready, 1'b1);
    check(wready, 1'b1);
    bready = 1'b1;
    mem_q.delete();
    bid_q.delete();
    @(negedge clk);
    u_awslv_master.send(32'h304, 4'h6, 32'h8765_4321, 4'h9);
    settle(1);
    expect_wr(32'h304, 32'h8765_4321, 4'h9, 4'h6);
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {rstn, bready, fail_count, check_count, cycles} = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    bready = 1'b1;
    repeat (2) @(negedge clk);
    t_lanes();
    t_stall();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
